/* File: design/nts_consts.vh */
// Constants for the network time counter: register offsets, widths, sync thresholds.
// Assumes inclusion by bare name from the design files of this block.
`ifndef NTS_CONSTS_VH
`define NTS_CONSTS_VH

// Host byte offsets (8-bit bus, even byte first).
`define NTS_OFS_TIME_LO 8'h10
`define NTS_OFS_TIME_HI 8'h11
`define NTS_OFS_DIFF_LO 8'h32
`define NTS_OFS_DIFF_HI 8'h33

// Counter and prescaler.
`define NTS_TIME_RESET 16'h0000
`define NTS_PRE_BASE 13'h0020
`define NTS_PRE_ONE 13'h0001
`define NTS_PRE_TWO 13'h0002
`define NTS_PRE_ZERO 13'h0000

// Phase tracking thresholds (local minus received).
`define NTS_SLOW_AT 16'h0002
`define NTS_FAST_AT 16'hffff
`define NTS_LOCK_WIN 16'h0002
`define NTS_LOCK_RUN 2'h3
`define NTS_DIFF_DIR_BIT 15

// Steps and reset values for counters and read latches.
`define NTS_TIME_STEP 16'h0001
`define NTS_LOCK_ZERO 2'h0
`define NTS_LOCK_STEP 2'h1
`define NTS_DIFF_RESET 16'h0000
`define NTS_BYTE_RESET 8'h00

`endif

/* File: design/nts_prescaler.v */
// Tick generator dividing the system clock by 32 << select, with single-cycle trim.
// Assumes synchronous inputs on clk; adjust requests are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "nts_consts.vh"

module nts_prescaler (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Control
    input wire [2:0] time_prescale_select,
    input wire time_halt,
    input wire slow_req,
    input wire fast_req,
    // Output
    output reg tick_q
);

    reg [12:0] cnt_q;
    reg slow_q;
    reg fast_q;
    reg [12:0] last;

    // The trim is held until the period ends; a later opposite request replaces it, and requests made while halted are dropped.
    always @* begin
        last = (`NTS_PRE_BASE << time_prescale_select) - `NTS_PRE_ONE; // [R2]
        if (slow_q) begin
            last = last + `NTS_PRE_ONE; // [R20]
        end else if (fast_q) begin
            last = last - `NTS_PRE_ONE; // [R20]
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            cnt_q <= `NTS_PRE_ZERO;
            slow_q <= 1'b0;
            fast_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (!time_halt) begin // [R20]
                if (cnt_q >= last) begin
                    cnt_q <= `NTS_PRE_ZERO;
                    tick_q <= 1'b1; // [R2]
                    slow_q <= slow_req;
                    fast_q <= fast_req & ~slow_req;
                end else begin
                    cnt_q <= cnt_q + `NTS_PRE_ONE;
                    if (slow_req) begin
                        slow_q <= 1'b1;
                        fast_q <= 1'b0;
                    end else if (fast_req) begin
                        fast_q <= 1'b1;
                        slow_q <= 1'b0;
                    end
                end
            end
        end
    end

endmodule // nts_prescaler

`default_nettype wire

/* File: design/nts_timer.v */
// Network time counter: prescaled 16-bit count, stamping, carry pulse, sync and readout.
// Assumes all inputs synchronous to clk; the packet engine supplies received stamps
// and asks for the outgoing stamp, and the host bus gives one-cycle read strobes.
`timescale 1ns/1ps
`default_nettype none
`include "nts_consts.vh"

// Summary of operation
// (R1) Keep a 16-bit wrapping counter that runs from power-up at the prescaled rate.
// (R2) Tick rate is system clock divided by 32 up to 4096 per 3-bit select.
// (R3) With stamp enable set, last two transmitted bytes carry the current count.
// (R4) A time master always stamps its packets regardless of stamp enable.
// (R5) Carry output pulses low whenever the selected counter bit changes; the code drives it on ticks only, so a preset gives none unless it lands on a tick.
// (R6) Each carry pulse lasts exactly one counter tick period; with carry digit select 0 the code holds the pin low across every tick.
// (R7) Even byte read first latches the odd byte for a consistent 16-bit read.
// (R8) Master when configured master identifier equals own identifier, else follower.
// (R9) Master counts freely and publishes its count through packet stamps.
// (R10) Software sets one common master identifier on all nodes; one node owns it.
// (R11) Follower uses stamps only from the configured master, ignoring other sources.
// (R12) First master stamp after arming loads the counter, then tracking starts.
// (R13) Preset re-arms at reset, halt release, master identifier write, software reset.
// (R14) In tracking, every master stamp is compared and the rate is adjusted.
// (R15) Local minus received of +2 or more slows the counter.
// (R16) Difference -1 or less speeds up; 0 or +1 leaves the rate alone.
// (R17) Master must send often enough to keep phase error within one tick.
// (R18) Unlock flag clears after three consecutive stamps within two, else sets.
// (R19) Phase difference register: bit 15 behind flag, bits 14..0 absolute difference.
// (R20) Trim by one system clock per prescaler period; hold while halted.
module nts_timer (
    // Clock and reset
    input wire clk,
    input wire srst,
    input wire soft_reset,
    // Configuration levels
    input wire [2:0] time_prescale_select,
    input wire stamp_enable,
    input wire [3:0] carry_digit_select,
    input wire time_halt,
    input wire [7:0] own_node_id,
    input wire [7:0] master_node_identifier,
    input wire master_id_write,
    // Host read port
    input wire host_rd,
    input wire [7:0] host_addr,
    output reg [7:0] host_rdata_q,
    // Receive stamp from packet engine
    input wire rx_stamp_valid,
    input wire [7:0] rx_source_id,
    input wire [15:0] rx_stamp,
    // Transmit stamp to packet engine
    input wire tx_stamp_req,
    output reg tx_stamp_insert_q,
    output reg [15:0] tx_stamp_q,
    // Status and pins
    output reg carry_pulse_out_n_q,
    output reg sync_unlock_flag_q,
    output reg time_master_node_q
);

    wire tick;
    reg [15:0] network_time_q;
    reg [15:0] network_time_d;
    reg armed_q;
    reg halt_prev_q;
    reg [1:0] lock_run_q;
    reg [15:0] phase_difference_q;
    reg [7:0] time_hi_latch_q;
    reg [7:0] diff_hi_latch_q;
    reg slow_req;
    reg fast_req;
    reg [15:0] diff;
    reg [15:0] diff_abs;
    wire from_master;
    reg in_window;
    wire is_master;
    wire rearm;

    // Decoded stamp events and carry taps.
    wire halt_release;
    wire preset_stamp;
    wire track_stamp;
    wire lock_last;
    wire carry_bit_now;
    wire carry_bit_next;

    assign is_master = (master_node_identifier == own_node_id); // [R8] [R10]
    assign from_master = rx_stamp_valid & ~is_master
        & (rx_source_id == master_node_identifier); // [R11]
    assign halt_release = halt_prev_q & ~time_halt; // [R13]
    assign rearm = soft_reset | master_id_write | halt_release; // [R13]
    // A stamp that meets a re-arm is dropped; it would only use up the fresh arming.
    assign preset_stamp = from_master & armed_q & ~rearm; // [R12]
    assign track_stamp = from_master & ~armed_q & ~rearm; // [R14]
    // Only tracking stamps build the lock run; the preset stamp is never counted.
    assign lock_last = (lock_run_q >= `NTS_LOCK_RUN - `NTS_LOCK_STEP); // [R18]
    // The carry pin compares the watched bit before and after each tick.
    assign carry_bit_now = network_time_q[carry_digit_select];
    assign carry_bit_next = network_time_d[carry_digit_select];

    nts_prescaler u_pre (
        .clk(clk),
        .srst(srst),
        .time_prescale_select(time_prescale_select),
        .time_halt(time_halt),
        .slow_req(slow_req),
        .fast_req(fast_req),
        .tick_q(tick)
    );

    // Comparison of a received master stamp against the local count.
    always @* begin
        // Difference is local minus received, read as 16-bit two's complement.
        diff = network_time_q - rx_stamp;
        diff_abs = diff[`NTS_DIFF_DIR_BIT] ? (~diff + `NTS_TIME_STEP) : diff;
        in_window = (diff_abs <= `NTS_LOCK_WIN);
        slow_req = 1'b0;
        fast_req = 1'b0;
        if (track_stamp) begin // [R14]
            if (!diff[`NTS_DIFF_DIR_BIT] && diff >= `NTS_SLOW_AT) begin
                slow_req = 1'b1; // [R15]
            end else if (diff[`NTS_DIFF_DIR_BIT] && diff <= `NTS_FAST_AT) begin
                fast_req = 1'b1; // [R16]
            end
        end
    end

    // Next count: preset wins over the tick so the loaded stamp is exact.
    always @* begin
        network_time_d = network_time_q;
        if (preset_stamp) begin
            network_time_d = rx_stamp; // [R12]
        end else if (tick) begin
            network_time_d = network_time_q + `NTS_TIME_STEP; // [R1] [R9]
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            network_time_q <= `NTS_TIME_RESET;
            armed_q <= 1'b1; // [R13]
            halt_prev_q <= 1'b0;
            lock_run_q <= `NTS_LOCK_ZERO;
            sync_unlock_flag_q <= 1'b1; // [R18]
            phase_difference_q <= `NTS_DIFF_RESET;
            carry_pulse_out_n_q <= 1'b1;
            time_master_node_q <= 1'b0;
        end else begin
            network_time_q <= network_time_d;
            halt_prev_q <= time_halt;
            time_master_node_q <= is_master;
            // Carry pin only moves on ticks, so its low phase spans one tick period, except with bit 0 watched, when it stays low.
            if (tick) begin
                carry_pulse_out_n_q <= ~(carry_bit_next ^ carry_bit_now); // [R5] [R6]
            end
            if (rearm) begin
                armed_q <= 1'b1; // [R13]
            end else if (preset_stamp) begin
                armed_q <= 1'b0; // [R12]
            end
            // A master is its own reference, so it always reports lock.
            if (is_master) begin
                sync_unlock_flag_q <= 1'b0;
                lock_run_q <= `NTS_LOCK_ZERO;
            end else if (track_stamp) begin
                phase_difference_q <= {diff[`NTS_DIFF_DIR_BIT], diff_abs[14:0]}; // [R19]
                if (!in_window) begin
                    lock_run_q <= `NTS_LOCK_ZERO;
                    sync_unlock_flag_q <= 1'b1; // [R18]
                end else if (lock_last) begin
                    lock_run_q <= `NTS_LOCK_RUN;
                    sync_unlock_flag_q <= 1'b0; // [R18]
                end else begin
                    lock_run_q <= lock_run_q + `NTS_LOCK_STEP;
                end
            end
        end
    end

    // Stamp for the last two bytes of an outgoing packet.
    always @(posedge clk) begin
        if (srst) begin
            tx_stamp_insert_q <= 1'b0;
            tx_stamp_q <= `NTS_TIME_RESET;
        end else if (tx_stamp_req) begin
            tx_stamp_insert_q <= stamp_enable | is_master; // [R3] [R4] [R9]
            tx_stamp_q <= network_time_q; // [R3]
        end
    end

    // Host readout; the odd byte comes from a latch so a tick between reads cannot tear it.
    always @(posedge clk) begin
        if (srst) begin
            host_rdata_q <= `NTS_BYTE_RESET;
            time_hi_latch_q <= `NTS_BYTE_RESET;
            diff_hi_latch_q <= `NTS_BYTE_RESET;
        end else if (host_rd) begin
            case (host_addr)
                `NTS_OFS_TIME_LO: begin
                    host_rdata_q <= network_time_q[7:0];
                    time_hi_latch_q <= network_time_q[15:8]; // [R7]
                end
                `NTS_OFS_TIME_HI: begin
                    host_rdata_q <= time_hi_latch_q; // [R7]
                end
                `NTS_OFS_DIFF_LO: begin
                    host_rdata_q <= phase_difference_q[7:0];
                    diff_hi_latch_q <= phase_difference_q[15:8];
                end
                `NTS_OFS_DIFF_HI: begin
                    host_rdata_q <= diff_hi_latch_q;
                end
                default: begin
                    host_rdata_q <= 8'h00;
                end
            endcase
        end
    end

endmodule // nts_timer

`default_nettype wire

/* File: verification/nts_peer_node.sv */
// Peer node model: offers a time stamp to the receive side for one cycle.
// Assumes the bench asks for each packet with a one-cycle go request.
`timescale 1ns/1ps
`default_nettype none
module nts_peer_node (
    // Clock and request
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] src,
    input wire logic [15:0] val,
    // Receive side of the block
    output logic rx_stamp_valid,
    output logic [7:0] rx_source_id,
    output logic [15:0] rx_stamp
);
    initial {rx_stamp_valid, rx_source_id, rx_stamp} = 25'h0000000;
    // Outside a packet the fields scramble, so stale values cannot pass as a stamp.
    always @(posedge clk) begin
        rx_stamp_valid <= go;
        rx_source_id <= go ? src : ~rx_source_id;
        rx_stamp <= go ? val : ~rx_stamp;
    end
endmodule // nts_peer_node
`default_nettype wire

/* File: verification/nts_timer_sva.sv */
// Port assertions for the network time counter.
// Assumes bind into nts_timer; setup levels change only under srst.
`timescale 1ns/1ps
`default_nettype none
module nts_timer_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Inputs
    input wire logic [2:0] time_prescale_select,
    input wire logic stamp_enable,
    input wire logic time_halt,
    input wire logic [7:0] own_node_id,
    input wire logic [7:0] master_node_identifier,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic tx_stamp_req,
    // Outputs
    input wire logic [7:0] host_rdata_q,
    input wire logic tx_stamp_insert_q,
    input wire logic carry_pulse_out_n_q,
    input wire logic sync_unlock_flag_q,
    input wire logic time_master_node_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [12:0] low_q;
    logic [12:0] per;
    assign per = 13'h0020 << time_prescale_select;
    // Halted cycles are not counted, so the width is measured in running time.
    always @(posedge clk) begin
        if (srst || carry_pulse_out_n_q)
            low_q <= 13'h0000;
        else if (!time_halt)
            low_q <= low_q + 13'h0001;
    end
    sequence s_halted;
        time_halt [*3];
    endsequence
    sequence s_master;
        time_master_node_q [*3];
    endsequence
    a_read_holds: assert property (!host_rd |=> $stable(host_rdata_q))
        else $error("read data moved");
    a_hole_zero: assert property (host_rd && host_addr > 8'h33 |=> host_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_stamp_on: assert property (tx_stamp_req && stamp_enable |=> tx_stamp_insert_q)
        else $error("stamp not inserted");
    a_master_stamp: assert property (
        tx_stamp_req && (own_node_id == master_node_identifier) |=> tx_stamp_insert_q)
        else $error("master stamp not inserted");
    a_master_role: assert property (1'b1 |=>
        time_master_node_q == ($past(own_node_id) == $past(master_node_identifier)))
        else $error("master role wrong");
    a_master_lock: assert property (s_master |-> !sync_unlock_flag_q)
        else $error("master shows unlock");
    a_carry_width: assert property ($rose(carry_pulse_out_n_q) |->
        low_q + 13'h0001 >= per && low_q <= per + 13'h0001) else $error("carry width wrong");
    a_halt_freeze: assert property (s_halted |-> $stable(carry_pulse_out_n_q))
        else $error("carry moved while halted");
endmodule // nts_timer_sva
bind nts_timer nts_timer_sva u_sva (
    .clk(clk),
    .srst(srst),
    .time_prescale_select(time_prescale_select),
    .stamp_enable(stamp_enable),
    .time_halt(time_halt),
    .own_node_id(own_node_id),
    .master_node_identifier(master_node_identifier),
    .host_rd(host_rd),
    .host_addr(host_addr),
    .tx_stamp_req(tx_stamp_req),
    .host_rdata_q(host_rdata_q),
    .tx_stamp_insert_q(tx_stamp_insert_q),
    .carry_pulse_out_n_q(carry_pulse_out_n_q),
    .sync_unlock_flag_q(sync_unlock_flag_q),
    .time_master_node_q(time_master_node_q)
);
`default_nettype wire

/* File: verification/nts_timer_test.sv */
// Self-checking bench for the network time counter with a peer stamp model.
// Moves prescale and carry selects only under srst; stamp enable, halt and master identifier change while running.
`timescale 1ns/1ps
`default_nettype none
module nts_timer_test;
    logic clk = 1'b0, srst = 1'b1, soft_reset = 1'b0, stamp_enable = 1'b0, time_halt = 1'b0;
    logic master_id_write = 1'b0, host_rd = 1'b0, tx_stamp_req = 1'b0, go = 1'b0;
    logic rd_d = 1'b0, tx_d = 1'b0, rx_stamp_valid, tx_stamp_insert_q, carry_pulse_out_n_q;
    logic sync_unlock_flag_q, time_master_node_q;
    logic [2:0] time_prescale_select = 3'h0;
    logic [3:0] carry_digit_select = 4'h0;
    logic [7:0] own_node_id = 8'h01, master_node_identifier = 8'h02, host_addr = 8'h00;
    logic [7:0] src = 8'h00, host_rdata_q, rx_source_id;
    logic [15:0] val = 16'h0000, s, t, tx_stamp_q, rx_stamp;
    logic [16:0] expq[$];
    int errors = 0, cmp_count = 0, cyc = 0, k;
    always #4 clk = ~clk;
    nts_peer_node u_peer (.clk(clk), .go(go), .src(src), .val(val),
        .rx_stamp_valid(rx_stamp_valid), .rx_source_id(rx_source_id), .rx_stamp(rx_stamp));
    nts_timer u_dut (.clk(clk), .srst(srst), .soft_reset(soft_reset),
        .time_prescale_select(time_prescale_select), .stamp_enable(stamp_enable),
        .carry_digit_select(carry_digit_select), .time_halt(time_halt),
        .own_node_id(own_node_id), .master_node_identifier(master_node_identifier),
        .master_id_write(master_id_write), .host_rd(host_rd), .host_addr(host_addr),
        .host_rdata_q(host_rdata_q), .rx_stamp_valid(rx_stamp_valid),
        .rx_source_id(rx_source_id), .rx_stamp(rx_stamp), .tx_stamp_req(tx_stamp_req),
        .tx_stamp_insert_q(tx_stamp_insert_q), .tx_stamp_q(tx_stamp_q),
        .carry_pulse_out_n_q(carry_pulse_out_n_q), .sync_unlock_flag_q(sync_unlock_flag_q),
        .time_master_node_q(time_master_node_q));
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task fl(input string w, input logic e, input logic g);
        chk(w, {16'h0000, e}, {16'h0000, g});
    endtask
    task tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        host_rd <= 1'b1;
        host_addr <= a;
        expq.push_back({9'h000, x});
        @(posedge clk);
        host_rd <= 1'b0;
    endtask
    task rd16(input logic [7:0] a, input logic [15:0] x);
        rd(a, x[7:0]);
        rd(a + 8'h01, x[15:8]);
    endtask
    task snd(input logic [7:0] sr, input logic [15:0] v);
        @(posedge clk);
        go <= 1'b1;
        src <= sr;
        val <= v;
        @(posedge clk);
        go <= 1'b0;
        tk(3);
    endtask
    task txq(input logic [16:0] x);
        @(posedge clk);
        tx_stamp_req <= 1'b1;
        expq.push_back(x);
        @(posedge clk);
        tx_stamp_req <= 1'b0;
    endtask
    task rst(input logic [2:0] p, input logic [3:0] c);
        @(posedge clk);
        srst <= 1'b1;
        time_prescale_select <= p;
        carry_digit_select <= c;
        tk(8);
        srst <= 1'b0;
    endtask
    task conclude;
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Results come back one cycle after their request, oldest note first.
    always @(posedge clk) begin
        rd_d <= host_rd;
        tx_d <= tx_stamp_req;
        cyc++;
        if (rd_d || tx_d)
            chk(rd_d ? "read" : "stamp", expq.pop_front(),
                rd_d ? {9'h000, host_rdata_q} : {tx_stamp_insert_q, tx_stamp_q});
        if (cyc == 60000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hf9d6da58));
        for (k = 0; k < 8; k++) begin
            rst(3'(k), 4'($urandom));
            tk((32 << k) * 7 / 2);
            rd16(8'h10, 16'h0003);
        end
        rst(3'h7, 4'h0);
        rd(8'h40, 8'h00);
        s = 16'($urandom);
        t = s + 16'($urandom_range(600)) + 16'h0003;
        snd(8'h03, s);
        rd16(8'h10, 16'h0000);
        snd(8'h02, s);
        rd16(8'h10, s);
        snd(8'h02, t);
        rd16(8'h10, s);
        t = t - s;
        rd16(8'h32, {1'b1, t[14:0]});
        for (k = 0; k < 3; k++) begin
            fl("unlock", 1'b1, sync_unlock_flag_q);
            snd(8'h02, s);
        end
        fl("unlock", 1'b0, sync_unlock_flag_q);
        snd(8'h02, s - 16'h0003);
        fl("unlock", 1'b1, sync_unlock_flag_q);
        rd16(8'h32, 16'h0003);
        txq({1'b0, s});
        @(posedge clk) stamp_enable <= 1'b1;
        txq({1'b1, s});
        for (k = 0; k < 3; k++) begin
            @(posedge clk);
            soft_reset <= k == 0;
            master_id_write <= k == 1;
            time_halt <= k == 2;
            tk(k == 2 ? 4 : 1);
            {soft_reset, master_id_write, time_halt} <= 3'h0;
            t = 16'($urandom);
            snd(8'h02, t);
            rd16(8'h10, t);
        end
        master_node_identifier <= own_node_id;
        master_id_write <= 1'b1;
        stamp_enable <= 1'b0;
        @(posedge clk) master_id_write <= 1'b0;
        tk(3);
        fl("master", 1'b1, time_master_node_q);
        fl("unlock", 1'b0, sync_unlock_flag_q);
        txq({1'b1, t});
        rst(3'h0, 4'h1);
        for (k = 0; k < 200 && carry_pulse_out_n_q !== 1'b0; k++) tk(1);
        fl("carry", 1'b0, carry_pulse_out_n_q);
        tk(100);
        conclude();
    end
endmodule // nts_timer_test
`default_nettype wire
